/* File: src/dac_serial_pkg.sv */
// constants shared by the serial-input converter frame logic
package dac_serial_pkg;
  // frame layout: msb first, code in the low bits, mode bits above it
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned CODE_W     = 12;
  localparam int unsigned CODE_LSB   = 0;
  localparam int unsigned MODE_LSB   = 12;
  localparam int unsigned MODE_W     = 2;

  // last edge index of a frame, at the width of the edge counter
  localparam logic [CNT_W-1:0] LAST_EDGE = 5'h0f;
  localparam logic [CNT_W-1:0] FULL_CNT  = 5'h10;

  // reset values
  localparam logic [CODE_W-1:0]     CODE_RESET  = 12'h000;
  localparam logic [FRAME_BITS-1:0] FRAME_RESET = 16'h0000;

  // timing: fastest serial clock the host may run, and the system clock
  localparam int unsigned SCLK_MAX_MHZ       = 30;
  localparam int unsigned CLK_PERIOD_NS      = 20;
  localparam int unsigned SCLK_MIN_PERIOD_PS = (1000000 + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
  // system clocks spanned by one full frame at the fastest serial clock
  localparam int unsigned FRAME_MIN_CLKS =
    (FRAME_BITS * SCLK_MIN_PERIOD_PS) / (CLK_PERIOD_NS * 1000);

  // operating mode carried in the mode bits, normal first
  typedef enum logic [MODE_W-1:0] {
    MODE_NORMAL,
    MODE_PD_LOW_LOAD,
    MODE_PD_HIGH_LOAD,
    MODE_PD_FLOAT
  } pd_mode_t;
endpackage

/* File: src/dac_serial_input_frame.sv */
// serial write port of a single-channel 12-bit converter: link shifter and update logic
//
// Notes on behaviour
// - sample data on falling serial clock, shift in
// - frame sync low enables shifter; high idles it
// - sixteenth falling edge updates the converter word
// - early sync rise aborts; converter stays unchanged
// - output holds zero until first complete write
// - write frames select normal or three power-downs
`timescale 1ns/1ps

module dac_serial_input_frame
  import dac_serial_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              sclk,
  input  wire logic              sync_n,
  input  wire logic              din,
  output logic [CODE_W-1:0]      analog_output,
  output pd_mode_t               pd_mode,
  output logic                   written,
  output logic                   update
);

  // link domain, clocked by falling edges of the serial clock
  logic [CNT_W-1:0]       cnt_ff;
  logic [FRAME_BITS-1:0]  shift_ff;
  logic [FRAME_BITS-1:0]  hold_ff;
  logic                   tog_ff;
  logic [FRAME_BITS-1:0]  nxt_shift;

  // next shift value: msb arrives first, so new bits enter at the bottom
  assign nxt_shift = {shift_ff[FRAME_BITS-2:0], din};

  // edge counter; sync high clears it at once, so a partial frame is
  // forgotten even when the serial clock has already stopped
  always_ff @(negedge sclk or posedge sync_n or posedge rst) begin
    if (rst || sync_n) begin
      cnt_ff <= '0;
    end else if (cnt_ff < FULL_CNT) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  // shifter runs only inside an open frame; edges past the sixteenth are ignored;
  // reset gives it known contents so the first frame never shifts unknowns
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      shift_ff <= FRAME_RESET;
    end else if (!sync_n && cnt_ff < FULL_CNT) begin
      shift_ff <= nxt_shift;
    end
  end

  // completed word is parked in a holding register that only the
  // sixteenth edge writes, so an aborted frame never reaches it
  always_ff @(negedge sclk) begin
    if (!sync_n && cnt_ff == LAST_EDGE) begin
      hold_ff <= nxt_shift;
    end
  end

  // one toggle per completed frame tells the system domain a word waits
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      tog_ff <= 1'b0;
    end else if (!sync_n && cnt_ff == LAST_EDGE) begin
      tog_ff <= ~tog_ff;
    end
  end

  // system domain
  logic                tog_meta_ff;
  logic                tog_sync_ff;
  logic                tog_seen_ff;
  logic                new_word;
  logic [CODE_W-1:0]   code_ff;
  pd_mode_t            mode_ff;
  logic                written_ff;
  logic                update_ff;

  // two-flop crossing of the toggle; the first flop feeds nothing else
  always_ff @(posedge clk) begin
    if (rst) begin
      tog_meta_ff <= 1'b0;
      tog_sync_ff <= 1'b0;
    end else if (ce) begin
      tog_meta_ff <= tog_ff;
      tog_sync_ff <= tog_meta_ff;
    end
  end

  assign new_word = tog_sync_ff != tog_seen_ff;

  // remember which toggle has been consumed
  always_ff @(posedge clk) begin
    if (rst) begin
      tog_seen_ff <= 1'b0;
    end else if (ce) begin
      tog_seen_ff <= tog_sync_ff;
    end
  end

  // the holding register is read here without its own crossing: it was
  // written at least two system clocks earlier and cannot change again
  // before another sixteen serial edges; holding ce low across a whole
  // following frame breaks that margin and may tear the word
  always_ff @(posedge clk) begin
    if (rst) begin
      code_ff <= CODE_RESET;
    end else if (ce && new_word) begin
      code_ff <= hold_ff[CODE_LSB +: CODE_W];
    end
  end

  // mode bits pick normal operation or one of three power-down states
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= MODE_NORMAL;
    end else if (ce && new_word) begin
      mode_ff <= pd_mode_t'(hold_ff[MODE_LSB +: MODE_W]);
    end
  end

  // sticky flag: a complete write has been accepted since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      written_ff <= 1'b0;
    end else if (ce && new_word) begin
      written_ff <= 1'b1;
    end
  end

  // one-cycle update strobe per accepted frame
  always_ff @(posedge clk) begin
    if (rst) begin
      update_ff <= 1'b0;
    end else if (ce) begin
      update_ff <= new_word;
    end
  end

  assign analog_output = code_ff;
  assign pd_mode       = mode_ff;
  assign written       = written_ff;
  assign update        = update_ff;

  // assertion helper: set by reset, cleared by the next serial edge; at that
  // edge sampled history still predates the reset and must not be trusted
  logic rst_mark_ff;

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rst_mark_ff <= 1'b1;
    end else begin
      rst_mark_ff <= 1'b0;
    end
  end

  // checks, link domain
  AST_SHIFT_ON_FALL: assert property (
    @(negedge sclk) disable iff (rst || sync_n)
    cnt_ff < FULL_CNT |=> shift_ff[0] == $past(din) && shift_ff[1] == $past(shift_ff[0]))
    else $error("shifter did not take the data bit on a falling edge");

  AST_FRAME_DONE: assert property (
    @(negedge sclk) disable iff (rst || sync_n)
    cnt_ff == LAST_EDGE |=> tog_ff != $past(tog_ff) && hold_ff == $past(nxt_shift))
    else $error("sixteenth edge did not hand over the word");

  AST_NO_PARTIAL: assert property (
    @(negedge sclk) disable iff (rst)
    !rst_mark_ff && tog_ff != $past(tog_ff) |-> $past(cnt_ff) == LAST_EDGE && !$past(sync_n))
    else $error("word handed over without a full frame");

  // checks, system domain
  AST_IDLE_WHEN_HIGH: assert property (
    @(posedge clk) disable iff (rst)
    sync_n |-> cnt_ff == '0)
    else $error("edge counter not cleared while frame sync is high");

  AST_UPDATE_CODE: assert property (
    @(posedge clk) disable iff (rst)
    ce && new_word |=> update_ff && analog_output == $past(hold_ff[CODE_LSB +: CODE_W]))
    else $error("accepted word did not reach the output code");

  AST_UPDATE_ONE_CYCLE: assert property (
    @(posedge clk) disable iff (rst)
    update_ff && ce |=> !update_ff)
    else $error("update strobe stood longer than one cycle");

  AST_ZERO_UNTIL_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    !written_ff |-> analog_output == CODE_RESET && pd_mode == MODE_NORMAL)
    else $error("output left zero before the first write");

  AST_MODE_FROM_WORD: assert property (
    @(posedge clk) disable iff (rst)
    update_ff |-> pd_mode == pd_mode_t'($past(hold_ff[MODE_LSB +: MODE_W])))
    else $error("mode bits not taken from the accepted word");

  AST_HOLD_BETWEEN: assert property (
    @(posedge clk) disable iff (rst)
    !update_ff && !$past(rst) |-> $stable(analog_output) && $stable(pd_mode))
    else $error("output changed without an update strobe");

  // main scenarios
  COV_FIRST_WRITE: cover property (
    @(posedge clk) disable iff (rst) $rose(written_ff));

  COV_POWER_DOWN: cover property (
    @(posedge clk) disable iff (rst) update_ff && pd_mode != MODE_NORMAL);

  COV_ABORT: cover property (
    @(negedge sclk) disable iff (rst)
    !sync_n && cnt_ff > 5'h00 && cnt_ff < LAST_EDGE ##1 cnt_ff == 5'h00);

  COV_BACK_TO_BACK: cover property (
    @(posedge clk) disable iff (rst) update_ff ##[1:40] update_ff);

  COV_FROZEN: cover property (
    @(posedge clk) disable iff (rst) !ce ##1 ce ##[1:3] update_ff);

endmodule // dac_serial_input_frame

/* File: verif/serial_host_model.sv */
// host-side serial master model that drives write frames into the converter port
`timescale 1ns/1ps

module serial_host_model (
  output logic sclk,
  output logic sync_n,
  output logic din
);
  // 17 ns half period: a 30 ns period would run past the serial clock ceiling
  localparam int HALF = 17;

  // idle: clock stands high, frame closed
  initial begin
    sclk   = 1'b1;
    sync_n = 1'b1;
    din    = 1'b0;
  end

  // one frame of n falling edges, msb first; clock stands still outside frames
  task automatic send(input logic [15:0] w, input int n);
    int i;
    sync_n = 1'b0;
    for (i = 0; i < n; i++) begin
      din = (i < 16) ? w[15-i] : 1'b1;
      #HALF sclk = 1'b0;
      #HALF sclk = 1'b1;
    end
    #HALF sync_n = 1'b1;
    din = ~din; // released line never shows the last bit
  endtask
endmodule // serial_host_model

/* File: verif/dac_serial_input_frame_tb.sv */
// self-checking bench for the serial-input converter frame logic
`timescale 1ns/1ps

module dac_serial_input_frame_tb
  import dac_serial_pkg::*;
;
  logic              clk;
  logic              rst;
  logic              ce;
  logic              sclk;
  logic              sync_n;
  logic              din;
  logic              written;
  logic              update;
  logic [CODE_W-1:0] analog_output;
  logic [CODE_W-1:0] exp_code;
  pd_mode_t          pd_mode;
  logic [MODE_W-1:0] exp_mode;
  logic              exp_wr;
  int                n_mismatch;
  int                cmp_count;
  int                cyc;
  int                m;

  dac_serial_input_frame i_dut (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .sync_n(sync_n),
    .din(din), .analog_output(analog_output), .pd_mode(pd_mode), .written(written),
    .update(update));
  serial_host_model i_host (.sclk(sclk), .sync_n(sync_n), .din(din));

  // system clock, 20 ns period
  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // code, mode and written outputs against the state the bench expects
  task automatic check_outputs();
    check(analog_output, exp_code);
    check(pd_mode, exp_mode);
    check(written, exp_wr);
  endtask

  // reset for n cycles; outputs must read zero afterwards
  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) @(posedge clk);
    #1 rst = 1'b0;
    exp_code = CODE_RESET;
    exp_mode = 2'h0;
    exp_wr   = 1'b0;
    check_outputs();
  endtask

  // one frame, watching for a single-cycle update pulse within a bounded wait
  task automatic frame(input logic [15:0] w, input int n, input logic take);
    int   k;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    #1;
    fork
      i_host.send(w, n);
      begin
        for (k = 0; k < 30 && !seen; k++) begin
          @(posedge clk);
          #1;
          seen = (update === 1'b1);
        end
        if (seen) begin
          @(posedge clk);
          #1;
          check(update, 1'b0);
        end
      end
    join
    check(seen, take);
    if (take) begin
      exp_code = w[11:0];
      exp_mode = w[13:12];
      exp_wr   = 1'b1;
    end
    check_outputs();
  endtask

  // ce drops after the sixteenth edge: the word must wait until ce returns
  task automatic frozen_frame(input logic [15:0] w);
    int   k;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    #1;
    fork
      i_host.send(w, 16);
      begin
        repeat (16) @(negedge sclk);
        @(posedge clk);
        #1 ce = 1'b0;
      end
    join
    repeat (8) @(posedge clk);
    #1;
    check(update, 1'b0);
    check_outputs();
    ce = 1'b1;
    for (k = 0; k < 6 && !seen; k++) begin
      @(posedge clk);
      #1;
      seen = (update === 1'b1);
    end
    check(seen, 1'b1);
    @(posedge clk);
    #1;
    check(update, 1'b0);
    exp_code = w[11:0];
    exp_mode = w[13:12];
    exp_wr   = 1'b1;
    check_outputs();
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    // reset rises after time zero so the link side sees a clean edge
    rst = 1'b0;
    ce  = 1'b1;
    #1;
    do_reset(20);
    frame(16'h5a3c, 5, 1'b0);
    frame(16'h0fff, 15, 1'b0);
    // every mode, junk in the top bits, surplus edges after the sixteenth
    for (m = 0; m < 4; m++) begin
      frame({2'b10, m[1:0], 12'(12'h9c6 + m * 273)}, 16 + m, 1'b1);
    end
    frozen_frame(16'h1e17);
    frame(16'h0123, 10, 1'b0);
    do_reset(2);
    frame(16'h0abc, 16, 1'b1);
    report_and_stop();
  end
endmodule // dac_serial_input_frame_tb
